// ### logic/rcd_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the dram controller
// Assumes: host clock of 125 MHz
// Notes:   included by the controller modules only
`ifndef RCD_CONSTS_SVH
`define RCD_CONSTS_SVH
// configuration space offsets
`define RCD_OFF_MEMCTL  8'h57
`define RCD_OFF_TIMING  8'h58
`define RCD_OFF_STATUS  8'h59
`define RCD_OFF_BND0    8'h60
`define RCD_OFF_ROWTYPE 8'h68
`define RCD_OFF_SYSTEM_MGMT_MEMORY   8'h72
// field positions and reset value
`define RCD_MC_EDO_DETECT_ENABLE     2
`define RCD_MC_RATE_LSB 3
`define RCD_SM_EN       3
`define RCD_RST_CFG     8'h00
// cycle figures; leadoffs counted from address strobe to ready, rates between readies
`define RCD_LEAD_HIT    4'h7
`define RCD_LEAD_ROWMIS 4'h9
`define RCD_LEAD_PGMISS 4'hc
`define RCD_LEAD_BB     4'h3
`define RCD_LEAD_WR     4'h3
`define RCD_RATE_EDO    4'h2
`define RCD_RATE_STD    4'h3
`define RCD_RATE_WR     4'h1
`define RCD_RETIRE      4'h3
`define RCD_REF_RAS     4'h4
`define RCD_BURST_LAST  2'h3
`define RCD_WR_QWORDS   3'h4
// refresh interval: time in ns, cycles rounded down
`define RCD_CLK_NS      8
`define RCD_REF_NS      15600
`define RCD_REF_CYC     (`RCD_REF_NS / `RCD_CLK_NS)
// a and b segments, address bits 26:17
`define RCD_AB_SEG      10'h005
`endif

// ### logic/rcd_pkg.sv
// Purpose: types shared by the dram controller modules
// Assumes: five dram rows
// Notes:   numeric constants live in rcd_consts.svh
package rcd_pkg;
    localparam int RCD_ROWS = 5;

    // gray codes along idle, busy, retire; refresh off the main path
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_WRET = 2'b11,
        ST_REFR = 2'b10
    } rcd_state_t;

    typedef struct packed {
        rcd_state_t             st;
        logic [3:0]             cnt;
        logic [3:0]             rate;
        logic [1:0]             beat;
        logic [2:0]             wr;
        logic                   wr_q;
        logic                   edo;
        logic                   b2b;
        logic                   pend;
        logic                   pend_wr;
        logic [26:3]            pend_addr;
        logic                   open_v;
        logic [2:0]             open_row;
        logic [26:12]           open_page;
        logic [11:0]            col_a;
        logic [RCD_ROWS-1:0]    ras;
        logic [7:0]             cas;
        logic [11:0]            ma;
        logic [7:0]             memctl;
        logic [7:0]             rowtype;
        logic [7:0]             tmg;
        logic [RCD_ROWS*8-1:0]  bnd;
        logic [7:0]             smctl;
        logic [7:0]             rdata;
        logic                   deny;
    } rcd_regs_t;
endpackage

// ### logic/rcd_addr_dec.sv
// Purpose: row, system_mgmt_memory and multiplexed address decode for one address
// Assumes: row boundaries in 4 Mbyte units, ascending
// Notes:   purely combinational
`timescale 1ns/1ns
`include "rcd_consts.svh"
module rcd_addr_dec
    import rcd_pkg::*;
#(
    parameter int ROWS = RCD_ROWS
)
(
    // address under decode
    input  wire logic [26:3]        addr_i,
    // configuration
    input  wire logic [ROWS*8-1:0]  bnd_i,
    input  wire logic               system_mgmt_memory_en_i,
    // results
    output logic                    hit_o,
    output logic [2:0]              row_o,
    output logic                    system_mgmt_memory_o,
    output logic [ROWS-1:0]         pop_o,
    output logic [11:0]             row_addr_o,
    output logic [11:0]             col_addr_o
);
    if (ROWS < 1 || ROWS > 7)
        $error("rcd_addr_dec: ROWS must be 1 to 7");

    // lowest row whose boundary lies above the address; bit 3 set means none
    function automatic logic [3:0] find_row(input logic [7:0] unit,
                                            input logic [ROWS*8-1:0] b);
        find_row = 4'h8;
        for (int i = ROWS - 1; i >= 0; i--)
            if (unit < b[i*8 +: 8])
                find_row = {1'b0, 3'(i)};
    endfunction

    logic [3:0] fr;
    logic       ab;

    // system_mgmt_memory reserves a and b segments, else they fall outside dram
    always_comb
    begin
        fr      = find_row({3'h0, addr_i[26:22]}, bnd_i);
        ab      = (addr_i[26:17] == `RCD_AB_SEG);
        system_mgmt_memory_o = ab && system_mgmt_memory_en_i;
        hit_o   = !fr[3] && (!ab || system_mgmt_memory_en_i);
        row_o   = fr[2:0];
    end

    // row phase then 4 kbyte page offset on the low nine lines
    assign row_addr_o = {addr_i[24:23], addr_i[21:12]};
    assign col_addr_o = {1'b0, addr_i[24], addr_i[22], addr_i[11:3]};

    // a row is populated when its boundary moves past the one below
    for (genvar i = 0; i < ROWS; i++)
    begin : g_pop
        if (i == 0)
        begin : g_first
            assign pop_o[i] = (bnd_i[7:0] != 8'h00);
        end
        else
        begin : g_rest
            assign pop_o[i] = (bnd_i[i*8 +: 8] != bnd_i[(i-1)*8 +: 8]);
        end
    end
endmodule

// ### logic/rcd_refq.sv
// Purpose: refresh request timer and four-entry request queue
// Assumes: same clock as the controller
// Notes:   a request made while full is dropped, the queue saturates
`timescale 1ns/1ns
`include "rcd_consts.svh"
module rcd_refq
    import rcd_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    // control
    input  wire logic [1:0] rate_sel_i,
    input  wire logic       pop_i,
    // queue state
    output logic            empty_o,
    output logic            full_o,
    output logic [2:0]      level_o
);
    if (DEPTH < 1 || DEPTH > 7)
        $error("rcd_refq: DEPTH must be 1 to 7");

    localparam logic [12:0] BASE = 13'(`RCD_REF_CYC);

    logic [12:0] tmr_r;
    logic [12:0] limit;
    logic [2:0]  lvl_r;
    logic        tick;

    // 00 nominal, 01 twice as often, 10 half as often, 11 off
    always_comb
    begin
        unique case (rate_sel_i)
            2'h0:    limit = BASE;
            2'h1:    limit = BASE >> 1;
            2'h2:    limit = BASE << 1;
            default: limit = 13'h0000;
        endcase
        tick = (limit != 13'h0000) && (tmr_r >= limit - 13'h0001);
    end

    // timer and queue level, push and pop in one cycle cancel
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            tmr_r <= 13'h0000;
            lvl_r <= 3'h0;
        end
        else if (ce_i)
        begin
            tmr_r <= tick ? 13'h0000 : tmr_r + 13'h0001;
            if (tick && !pop_i && lvl_r != 3'(DEPTH))
                lvl_r <= lvl_r + 3'h1;
            else if (pop_i && !tick && lvl_r != 3'h0)
                lvl_r <= lvl_r - 3'h1;
        end
    end

    assign empty_o = (lvl_r == 3'h0);
    assign full_o  = (lvl_r == 3'(DEPTH));
    assign level_o = lvl_r;

    queue_cap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        lvl_r <= 3'(DEPTH)) else $error("refresh queue above depth");
endmodule

// ### logic/rcd_ctrl.sv
// Purpose: dram cycle engine, row typing, refresh arbitration and system_mgmt_memory guard
// Assumes: cpu strobes on the host clock; ce_i high for assertions to hold
// Notes:   configuration through the documented config write/read port
// Behaviour
// - page-mode read rows keep all column strobes low until data sampled.
// - edo rows may release column strobes before the sample point.
// - detection enable bit applies a special read timing for typing rows.
// - pipelined edo back-to-back page-hit reads run 7-2-2-2-3-2-2-2.
// - pipelined page-mode back-to-back page-hit reads run 7-3-3-3-3-3-3-3.
// - page miss reads take 12 to first data, then 3 or 2.
// - open page in another row adds two clocks: 9-2-2-2 or 9-3-3-3.
// - posted writes accepted 3-1-1-1, retired every 3 clocks.
// - read and write rates selectable by the timing register.
// - controller generates refresh at programmed rate as row-strobe-only cycles.
// - refresh requests wait in a queue of at most four.
// - partly filled queue refreshes only when nothing else pends.
// - full queue makes refresh the highest priority, served next.
// - a refresh request leaves the queue when its service begins.
// - bank 0 always refreshed, other banks only when populated.
// - enabled system_mgmt_memory reserves A0000-BFFFF, otherwise normal map.
// - pci masters are denied system_mgmt_memory in the a and b segments.
// - 4 kbyte pages, page offset on the low nine address lines.
// - five row strobes and eight column strobes, all eight driven together.
`timescale 1ns/1ns
`include "rcd_consts.svh"
module rcd_ctrl
    import rcd_pkg::*;
#(
    parameter int RQ_DEPTH = 4
)
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    input  wire logic               ce_i,
    // configuration port
    input  wire logic               cfg_wr_i,
    input  wire logic               cfg_rd_i,
    input  wire logic [7:0]         cfg_addr_i,
    input  wire logic [7:0]         cfg_wdata_i,
    output logic [7:0]              cfg_rdata_o,
    // cpu side
    input  wire logic               cpu_addr_strobe_n_i,
    input  wire logic               cpu_write_i,
    input  wire logic [26:3]        cpu_addr_i,
    output logic                    cpu_burst_ready_n_o,
    // pci master side
    input  wire logic               pci_req_i,
    input  wire logic [26:3]        pci_addr_i,
    output logic                    pci_system_mgmt_memory_deny_o,
    // dram and data path
    output logic [RCD_ROWS-1:0]     ras_n_o,
    output logic [7:0]              cas_n_o,
    output logic [11:0]             mux_row_col_addr_o,
    output logic                    dp_sample_o
);
    rcd_regs_t q;
    rcd_regs_t n;

    logic                   req_v;
    logic                   req_wr;
    logic [26:3]            req_addr;
    logic                   ads_v;
    logic                   hit;
    logic [2:0]             row;
    logic [RCD_ROWS-1:0]    pop;
    logic [11:0]            row_a;
    logic [11:0]            col_a;
    logic                   pci_ab;
    logic                   rf_empty;
    logic                   rf_full;
    logic                   rf_pop;
    logic                   beat;
    logic                   start;
    logic                   pg_hit;
    logic [3:0]             lead;

    // row select as one-hot strobe pattern
    function automatic logic [RCD_ROWS-1:0] row_hot(input logic [2:0] r);
        row_hot = '0;
        row_hot[r] = 1'b1;
    endfunction

    // a pipelined strobe waits in pend; the cpu pipelines one deep only
    assign req_v    = q.pend || ads_v;
    assign req_wr   = q.pend ? q.pend_wr : cpu_write_i;
    assign req_addr = q.pend ? q.pend_addr : cpu_addr_i;
    assign ads_v    = !cpu_addr_strobe_n_i && hit;

    rcd_addr_dec #(.ROWS(RCD_ROWS)) u_cpu_dec (
        .addr_i     (req_addr),
        .bnd_i      (q.bnd),
        .system_mgmt_memory_en_i (q.smctl[`RCD_SM_EN]),
        .hit_o      (hit),
        .row_o      (row),
        .system_mgmt_memory_o    (),
        .pop_o      (pop),
        .row_addr_o (row_a),
        .col_addr_o (col_a)
    );

    rcd_addr_dec #(.ROWS(RCD_ROWS)) u_pci_dec (
        .addr_i     (pci_addr_i),
        .bnd_i      (q.bnd),
        .system_mgmt_memory_en_i (q.smctl[`RCD_SM_EN]),
        .hit_o      (),
        .row_o      (),
        .system_mgmt_memory_o    (pci_ab),
        .pop_o      (),
        .row_addr_o (),
        .col_addr_o ()
    );

    rcd_refq #(.DEPTH(RQ_DEPTH)) u_refq (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .rate_sel_i (q.memctl[`RCD_MC_RATE_LSB +: 2]),
        .pop_i      (rf_pop),
        .empty_o    (rf_empty),
        .full_o     (rf_full),
        .level_o    ()
    );

    // leadoff by page state; timing register adds clocks on reads
    always_comb
    begin
        pg_hit = q.open_v && q.open_row == row && q.open_page == req_addr[26:12];
        if (req_wr)
            lead = `RCD_LEAD_WR;
        else if (pg_hit)
            lead = `RCD_LEAD_HIT + {2'h0, q.tmg[1:0]};
        else if (q.open_v && q.open_row == row)
            lead = `RCD_LEAD_PGMISS + {2'h0, q.tmg[1:0]};
        else
            lead = `RCD_LEAD_ROWMIS + {2'h0, q.tmg[1:0]};
    end

    assign beat = (q.st == ST_BUSY) && (q.cnt == 4'h0);

    // next-state of the whole controller
    always_comb
    begin
        n      = q;
        start  = 1'b0;
        rf_pop = 1'b0;
        n.deny = pci_req_i && pci_ab;
        if (cfg_wr_i)
        begin
            unique case (cfg_addr_i)
                `RCD_OFF_MEMCTL:  n.memctl  = cfg_wdata_i;
                `RCD_OFF_TIMING:  n.tmg     = cfg_wdata_i;
                `RCD_OFF_ROWTYPE: n.rowtype = cfg_wdata_i;
                `RCD_OFF_SYSTEM_MGMT_MEMORY:   n.smctl   = cfg_wdata_i;
                default:
                    for (int i = 0; i < RCD_ROWS; i++)
                        if (cfg_addr_i == `RCD_OFF_BND0 + 8'(i))
                            n.bnd[i*8 +: 8] = cfg_wdata_i;
            endcase
        end
        if (cfg_rd_i)
        begin
            unique case (cfg_addr_i)
                `RCD_OFF_MEMCTL:  n.rdata = q.memctl;
                `RCD_OFF_TIMING:  n.rdata = q.tmg;
                `RCD_OFF_ROWTYPE: n.rdata = q.rowtype;
                `RCD_OFF_SYSTEM_MGMT_MEMORY:   n.rdata = q.smctl;
                `RCD_OFF_STATUS:  n.rdata = {1'b0, q.open_v, q.st, rf_full, q.wr}; // top bit spare
                default:
                begin
                    n.rdata = 8'h00;
                    for (int i = 0; i < RCD_ROWS; i++)
                        if (cfg_addr_i == `RCD_OFF_BND0 + 8'(i))
                            n.rdata = q.bnd[i*8 +: 8];
                end
            endcase
        end
        unique case (q.st)
            ST_IDLE:
            begin
                if (rf_full || (!rf_empty && !req_v && !pci_req_i))
                begin
                    n.st     = ST_REFR;
                    n.cnt    = `RCD_REF_RAS - 4'h1;
                    n.open_v = 1'b0;
                    n.b2b    = 1'b0;
                    rf_pop   = 1'b1;
                end
                else if (req_v)
                begin
                    start       = 1'b1;
                    n.st        = ST_BUSY;
                    n.pend      = 1'b0;
                    n.wr_q      = req_wr;
                    n.beat      = 2'h0;
                    n.b2b       = 1'b0;
                    n.open_v    = 1'b1;
                    n.open_row  = row;
                    n.open_page = req_addr[26:12];
                    n.col_a     = col_a;
                    // detection forces edo strobing on every row
                    n.edo = q.rowtype[row] || q.memctl[`RCD_MC_EDO_DETECT_ENABLE];
                    n.cnt = (q.b2b && !req_wr) ? `RCD_LEAD_BB - 4'h2 : lead - 4'h1;
                    if (req_wr)
                        n.rate = `RCD_RATE_WR;
                    else
                        n.rate = (n.edo ? `RCD_RATE_EDO : `RCD_RATE_STD)
                                 + {3'h0, q.tmg[2]};
                end
            end
            ST_BUSY:
            begin
                if (q.cnt != 4'h0)
                    n.cnt = q.cnt - 4'h1;
                else if (q.beat != `RCD_BURST_LAST)
                begin
                    n.beat = q.beat + 2'h1;
                    n.cnt  = q.rate - 4'h1;
                end
                else if (q.wr_q)
                begin
                    n.st   = ST_WRET;
                    n.wr   = `RCD_WR_QWORDS;
                    n.beat = 2'h0;
                    n.cnt  = `RCD_RETIRE - 4'h1 + {3'h0, q.tmg[3]};
                end
                else
                begin
                    n.st  = ST_IDLE;
                    n.b2b = req_v && !req_wr && pg_hit;
                end
            end
            ST_WRET:
            begin
                if (q.cnt != 4'h0)
                    n.cnt = q.cnt - 4'h1;
                else if (q.wr == 3'h1)
                begin
                    n.st = ST_IDLE;
                    n.wr = 3'h0;
                end
                else
                begin
                    n.wr   = q.wr - 3'h1;
                    n.beat = q.beat + 2'h1;
                    n.cnt  = `RCD_RETIRE - 4'h1 + {3'h0, q.tmg[3]};
                end
            end
            ST_REFR:
            begin
                if (q.cnt == 4'h0)
                    n.st = ST_IDLE;
                else
                    n.cnt = q.cnt - 4'h1;
            end
        endcase
        // a strobe not started this cycle is held for later
        if (ads_v && !start)
        begin
            n.pend      = 1'b1;
            n.pend_wr   = cpu_write_i;
            n.pend_addr = cpu_addr_i;
        end
        // refresh strobes bank 0 and populated banks only, no column strobe;
        // its first cycle precharges all rows so an open row sees a fresh fall
        if (n.st == ST_REFR && n.cnt != `RCD_REF_RAS - 4'h1)
            n.ras = ~(pop | RCD_ROWS'(1));
        else
            n.ras = n.open_v ? ~row_hot(n.open_row) : '1;
        // page-mode reads hold column strobe through the sample cycle
        if (n.st == ST_BUSY && !n.wr_q)
            n.cas = (n.cnt == 4'h1 || (n.cnt == 4'h0 && !n.edo)) ? 8'h00 : 8'hff;
        else if (n.st == ST_WRET)
            n.cas = (n.cnt == 4'h0) ? 8'h00 : 8'hff;
        else
            n.cas = 8'hff;
        n.ma = start ? row_a : {n.col_a[11:2], n.col_a[1:0] + n.beat};
    end

    // single state register, frozen while ce_i is low
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            q         <= '0;
            q.st      <= ST_IDLE;
            q.ras     <= '1;
            q.cas     <= 8'hff;
            q.memctl  <= `RCD_RST_CFG;
            q.rowtype <= `RCD_RST_CFG;
            q.tmg     <= `RCD_RST_CFG;
            q.smctl   <= `RCD_RST_CFG;
        end
        else if (ce_i)
            q <= n;
    end

    assign cpu_burst_ready_n_o = !beat;
    assign dp_sample_o         = beat && !q.wr_q;
    assign cfg_rdata_o         = q.rdata;
    assign pci_system_mgmt_memory_deny_o    = q.deny;
    assign ras_n_o             = q.ras;
    assign cas_n_o             = q.cas;
    assign mux_row_col_addr_o  = q.ma;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i || !ce_i);

    sequence s_start_rd;
        start && !req_wr && !q.b2b && q.tmg[1:0] == 2'h0;
    endsequence
    sequence s_last_rd;
        beat && !q.wr_q && q.beat == `RCD_BURST_LAST;
    endsequence

    std_cas_hold_a: assert property (beat && !q.wr_q && !q.edo |-> cas_n_o == 8'h00)
        else $error("page-mode read released column strobe before sample");
    edo_cas_early_a: assert property (beat && !q.wr_q && q.edo |-> cas_n_o == 8'hff)
        else $error("edo read did not release column strobe early");
    detect_timing_a: assert property (start && !req_wr && q.memctl[2] |=> q.edo)
        else $error("detection mode did not force edo strobing");
    lead_hit_a: assert property (s_start_rd and (lead == 4'h7) |-> ##7 beat)
        else $error("page hit leadoff not 7");
    lead_rowmiss_a: assert property (s_start_rd and (lead == 4'h9) |-> ##9 beat)
        else $error("row miss leadoff not 9");
    lead_pgmiss_a: assert property (s_start_rd and (lead == 4'hc) |-> ##12 beat)
        else $error("page miss leadoff not 12");
    edo_rate_a: assert property (beat && !q.wr_q && q.rate == 4'h2 && q.beat != 2'h3
        |=> !beat ##1 beat) else $error("edo burst rate not 2");
    std_rate_a: assert property (beat && !q.wr_q && q.rate == 4'h3 && q.beat != 2'h3
        |=> !beat [*2] ##1 beat) else $error("page-mode burst rate not 3");
    b2b_gap_a: assert property ((s_last_rd and n.b2b) ##1 !rf_full |-> ##2 beat)
        else $error("back-to-back gap not 3");
    wr_accept_a: assert property (start && req_wr |-> ##3 beat [*4])
        else $error("posted write not 3-1-1-1");
    wr_retire_a: assert property (q.st == ST_WRET && q.cnt == 4'h0 && q.wr > 3'h1
        && q.tmg[3] == 1'b0 |-> ##3 (q.st == ST_WRET && q.cnt == 4'h0))
        else $error("retire spacing not 3");
    ref_priority_a: assert property (q.st == ST_IDLE && rf_full |=> q.st == ST_REFR)
        else $error("full refresh queue not served next");
    ref_quiet_a: assert property (q.st == ST_IDLE && n.st == ST_REFR && !rf_full
        |-> !req_v && !pci_req_i && rf_pop) else $error("refresh taken over pending request");
    ref_bank0_a: assert property (q.st == ST_REFR && q.cnt != `RCD_REF_RAS - 4'h1
        |-> !ras_n_o[0] && cas_n_o == 8'hff) else $error("bank 0 not refreshed");
    pci_deny_a: assert property (pci_req_i && pci_ab |=> pci_system_mgmt_memory_deny_o)
        else $error("pci access to system_mgmt_memory not denied");
endmodule

// ### tb/rcd_dram_rows.sv
// Purpose: row side model, watches strobes of the five dram rows
// Assumes: strobes active low, registered by the controller
// Notes:   no data bus here, so the model only classifies strobe cycles
`timescale 1ns/1ns
module rcd_dram_rows
    import rcd_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                nrst_i,
    // strobes, five rows by eight byte lanes
    input  wire logic [RCD_ROWS-1:0] ras_n_i,
    input  wire logic [7:0]          cas_n_i,
    // rows that saw a row-strobe-only cycle
    output logic [RCD_ROWS-1:0]      ref_seen_o
);
    logic [RCD_ROWS-1:0] ras_q;
    logic [RCD_ROWS-1:0] cas_hit;

    // row strobe ending with no column strobe seen is a refresh
    always_ff @(posedge clk_i)
    begin
        ras_q <= ras_n_i;
        if (!nrst_i)
        begin
            ref_seen_o <= '0;
            cas_hit    <= '0;
        end
        else
        begin
            for (int i = 0; i < RCD_ROWS; i++)
            begin
                if (ras_n_i[i] && !ras_q[i] && !cas_hit[i])
                    ref_seen_o[i] <= 1'b1;
                if (ras_n_i[i])
                    cas_hit[i] <= 1'b0;
                else if (cas_n_i != 8'hff)
                    cas_hit[i] <= 1'b1;
            end
        end
    end
endmodule

// ### tb/test_dram_mode_refresh_system_mgmt_memory_ctrl.sv
// Purpose: self-checking bench of the dram controller
// Assumes: ce_i held high; row 0 edo, row 1 page mode
// Notes:   half refresh interval keeps the run short
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module test_dram_mode_refresh_system_mgmt_memory_ctrl;
    logic        clk_i, nrst_i, wr, rd, as_n, cpu_wr, pci_req, rdy_n, deny, dp;
    logic [7:0]  cfg_a, cfg_d, rdata, cas_n;
    logic [26:3] cpu_a, pci_a;
    logic [4:0]  ras_n, seen;
    int          err_total = 0;
    int          cmp_count = 0;
    int          nret = 0;

    rcd_ctrl uut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .cfg_wr_i(wr), .cfg_rd_i(rd),
        .cfg_addr_i(cfg_a), .cfg_wdata_i(cfg_d), .cfg_rdata_o(rdata),
        .cpu_addr_strobe_n_i(as_n), .cpu_write_i(cpu_wr), .cpu_addr_i(cpu_a),
        .cpu_burst_ready_n_o(rdy_n), .pci_req_i(pci_req), .pci_addr_i(pci_a),
        .pci_system_mgmt_memory_deny_o(deny), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .mux_row_col_addr_o(), .dp_sample_o(dp));
    rcd_dram_rows rows (.clk_i(clk_i), .nrst_i(nrst_i), .ras_n_i(ras_n), .cas_n_i(cas_n),
        .ref_seen_o(seen));

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one config access; a read compares the returned byte
    task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        {wr, rd, cfg_a, cfg_d} = {w, !w, a, d};
        @(posedge clk_i);
        #1;
        {wr, rd} = 2'b00;
        if (!w)
            `CHK(rdata, d)
    endtask

    // one burst: ready gaps, and strobes at each read sample point
    task automatic cpu(input logic w, input logic [26:3] a, input int l0, input int r,
                       input logic [7:0] ecas, input int nb = 4);
        int last;
        int k;
        last = 0;
        k = 0;
        repeat (3) @(posedge clk_i);
        #1;
        {as_n, cpu_wr, cpu_a} = {1'b0, w, a};
        for (int n = 1; n < 60 && k < nb; n++)
        begin
            @(posedge clk_i);
            #1;
            // a second strobe just after the first ready pipelines a burst
            as_n = (n != last + 1) || (k != 1) || (nb == 4);
            if (rdy_n === 1'b0)
            begin
                `CHK(n - last, (k == 0) ? l0 : (k == 4) ? 3 : r)
                if (!w)
                    `CHK({dp, cas_n}, {1'b1, ecas})
                last = n;
                k++;
            end
        end
        if (k < nb)
        begin
            err_total++;
            final_report();
        end
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // reset, config, read and write timing, system_mgmt_memory guard, refresh
    initial
    begin
        {nrst_i, wr, rd, as_n, cpu_wr, pci_req} = 6'h04;
        {cfg_a, cfg_d, cpu_a, pci_a} = '0;
        repeat (6) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        cfg(0, 8'h57, 8'h00);
        cfg(0, 8'h90, 8'h00);
        cfg(1, 8'h60, 8'h01);
        for (int i = 1; i < 5; i++)
            cfg(1, 8'h60 + 8'(i), 8'h02);
        cfg(1, 8'h68, 8'h1f);
        cfg(1, 8'h68, 8'h01);
        cfg(0, 8'h68, 8'h01);
        cpu(0, 24'h0, 9, 2, 8'hff);
        cpu(0, 24'h0, 7, 2, 8'hff, 8);
        cpu(0, 24'h200, 12, 2, 8'hff);
        cpu(0, 24'h8_0000, 9, 3, 8'h00);
        cpu(0, 24'h8_0000, 7, 3, 8'h00, 8);
        cfg(1, 8'h58, 8'h05);
        cpu(0, 24'h8_0000, 8, 4, 8'h00);
        cfg(1, 8'h58, 8'h00);
        cfg(1, 8'h57, 8'h04);
        cpu(0, 24'h8_0000, 7, 2, 8'hff);
        cfg(1, 8'h57, 8'h00);
        cpu(1, 24'h8_0000, 3, 1, 8'h00);
        repeat (20)
        begin
            @(posedge clk_i);
            #1;
            nret += int'(cas_n === 8'h00);
        end
        `CHK(nret, 4)
        cfg(1, 8'h72, 8'h08);
        {pci_req, pci_a} = {1'b1, 24'h1_4000};
        @(posedge clk_i);
        #1;
        `CHK(deny, 1'b1)
        cfg(1, 8'h72, 8'h00);
        @(posedge clk_i);
        #1;
        `CHK(deny, 1'b0)
        pci_req = 1'b0;
        cfg(1, 8'h57, 8'h08);
        repeat (1100) @(posedge clk_i);
        `CHK(seen, 5'h03)
        final_report();
    end
endmodule
